// *** logic/rwg_pkg.sv ***
package rwg_pkg;
  // Register offsets on the 12-bit device address
  localparam logic [11:0] STATE_FLAGS_OFS = 12'h600;
  localparam logic [11:0] RANDOM_WORD_OFS = 12'h602;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned WORD_W = 32;
  // Status field positions
  localparam int unsigned OUTPUT_READY_BIT = 18;
  localparam int unsigned GEN_ON_BIT = 31;
  // Shift register geometry and seeds
  localparam int unsigned LFSR_W = 32;
  localparam int unsigned ASR_W = 37;
  localparam logic [31:0] LFSR_SEED = 32'h0000_0001;
  localparam logic [36:0] ASR_SEED = 37'h00_0000_0001;
  // Feedback taps for x^32 + x^22 + x^2 + x + 1
  localparam logic [31:0] LFSR_TAPS = 32'h8020_0003;
  // Cells set here use rule 150, the others rule 90
  localparam logic [36:0] ASR_RULE150 = 37'h10_0000_0000;
  // Oscillator steps counted after a read before a new word is offered
  localparam int unsigned ACCUM_STEPS = 32;
  localparam int unsigned BUF_DEPTH = 2;
  localparam logic [31:0] UNMAPPED_WORD = 32'h0000_0000;

  typedef enum logic [1:0] {
    RWG_OFF = 2'b00,
    RWG_ACCUM = 2'b01,
    RWG_READY = 2'b10
  } rwg_gen_state_t;
endpackage : rwg_pkg

// *** logic/rwg_stream_if.sv ***
interface rwg_stream_if #(parameter int unsigned WIDTH = 32);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : rwg_stream_if

// *** logic/rwg_word_buffer.sv ***
module rwg_word_buffer #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 2
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  rwg_stream_if.snk fill,
  rwg_stream_if.src drain
);
  if (DEPTH != 2)
  begin : g_bad_depth
    $error("rwg_word_buffer serves exactly two entries");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic wr_ptr_q;
  logic rd_ptr_q;
  logic [1:0] count_q;
  logic push;
  logic pop;

  assign fill.ready = (count_q != 2'h2);
  assign drain.valid = (count_q != 2'h0);
  assign drain.data = mem_q[rd_ptr_q];
  assign push = fill.valid && fill.ready;
  assign pop = drain.valid && drain.ready;

  ////////////////////////////////////////////////////////////////
  always_ff @(posedge clock_i)
  begin
    if (push)
      mem_q[wr_ptr_q] <= fill.data;
  end

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q <= 2'h0;
    end
    else
    begin
      if (push)
        wr_ptr_q <= ~wr_ptr_q;
      if (pop)
        rd_ptr_q <= ~rd_ptr_q;
      count_q <= 2'(count_q + {1'b0, push} - {1'b0, pop});
    end
  end
endmodule : rwg_word_buffer

// *** logic/rwg_generator.sv ***
// Functional notes
// - Each read of the random output register delivers one 32-bit word.
// - A linear feedback register and a cellular automata register run side by side.
// - Both registers step on their own oscillator edges, gated by a clock controller.
// - A random read swallows both oscillator edges in its sampling cycle and XORs selected bits into the 32-bit result.
// - Status bit 18 reads one while a random word is available, else zero.
// - Reading random output while not ready inserts wait states until ready.
// - Status bit 31 reads one while the generator is on and randomizing.
module rwg_generator #(
  parameter int unsigned ACCUM_STEPS = rwg_pkg::ACCUM_STEPS
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic gen_enable_i,
  input wire logic osc_lfsr_i,
  input wire logic osc_asr_i,
  input wire logic rd_en_i,
  input wire logic [rwg_pkg::ADDR_W-1:0] rd_addr_i,
  input wire logic rd_ready_i,
  output logic rd_busy_o,
  output logic rd_valid_o,
  output logic [rwg_pkg::WORD_W-1:0] rd_data_o,
  output logic output_ready_o
);
  // The step counter is 16 bits wide
  if (ACCUM_STEPS < 1 || ACCUM_STEPS > 65535)
  begin : g_bad_steps
    $error("ACCUM_STEPS must lie in 1..65535");
  end

  localparam logic [15:0] ACCUM_LAST = 16'(ACCUM_STEPS - 1);

  rwg_stream_if #(.WIDTH(rwg_pkg::WORD_W)) fill_if ();
  rwg_stream_if #(.WIDTH(rwg_pkg::WORD_W)) drain_if ();

  rwg_word_buffer #(.WIDTH(rwg_pkg::WORD_W), .DEPTH(rwg_pkg::BUF_DEPTH)) u_buf (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .fill(fill_if.snk),
    .drain(drain_if.src)
  );

  rwg_pkg::rwg_gen_state_t state_q;
  logic [rwg_pkg::LFSR_W-1:0] lfsr_q;
  logic [rwg_pkg::ASR_W-1:0] asr_q;
  logic osc_lfsr_q;
  logic osc_asr_q;
  logic [15:0] accum_q;
  logic pend_q;
  logic [rwg_pkg::ADDR_W-1:0] pend_addr_q;
  logic out_valid_q;
  logic [rwg_pkg::WORD_W-1:0] out_data_q;

  logic running;
  logic rand_fire;
  logic push_fire;
  logic step_lfsr;
  logic step_asr;
  logic [rwg_pkg::WORD_W-1:0] combined;
  logic [rwg_pkg::WORD_W-1:0] status_word;
  logic [rwg_pkg::WORD_W-1:0] answer;

  ////////////////////////////////////////////////////////////////
  // Clock controller
  assign running = (state_q != rwg_pkg::RWG_OFF);
  assign rand_fire = pend_q && (pend_addr_q == rwg_pkg::RANDOM_WORD_OFS)
    && (state_q == rwg_pkg::RWG_READY) && fill_if.ready;
  // Oscillator edges are swallowed in the sampling cycle so the word is frozen
  assign step_lfsr = running && osc_lfsr_i && !osc_lfsr_q && !rand_fire;
  assign step_asr = running && osc_asr_i && !osc_asr_q && !rand_fire;

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      osc_lfsr_q <= 1'b0;
      osc_asr_q <= 1'b0;
    end
    else
    begin
      osc_lfsr_q <= osc_lfsr_i;
      osc_asr_q <= osc_asr_i;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Shift registers
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
      lfsr_q <= rwg_pkg::LFSR_SEED;
    else if (step_lfsr)
      lfsr_q <= {lfsr_q[rwg_pkg::LFSR_W-2:0], ^(lfsr_q & rwg_pkg::LFSR_TAPS)};
  end

  // Null boundary; rule 90 is left xor right, rule 150 adds the cell itself
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
      asr_q <= rwg_pkg::ASR_SEED;
    else if (step_asr)
      asr_q <= {1'b0, asr_q[rwg_pkg::ASR_W-1:1]} ^ {asr_q[rwg_pkg::ASR_W-2:0], 1'b0}
        ^ (asr_q & rwg_pkg::ASR_RULE150);
  end

  // Two overlapping windows of the automaton decorrelate neighbouring bits
  assign combined = lfsr_q ^ asr_q[31:0] ^ asr_q[36:5];

  ////////////////////////////////////////////////////////////////
  // Accumulation state
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      state_q <= rwg_pkg::RWG_OFF;
      accum_q <= 16'h0000;
    end
    else if (!gen_enable_i)
    begin
      state_q <= rwg_pkg::RWG_OFF;
      accum_q <= 16'h0000;
    end
    else
    begin
      unique case (state_q)
        rwg_pkg::RWG_OFF:
        begin
          state_q <= rwg_pkg::RWG_ACCUM;
          accum_q <= 16'h0000;
        end
        rwg_pkg::RWG_ACCUM:
        begin
          if (step_lfsr)
          begin
            if (accum_q == ACCUM_LAST)
              state_q <= rwg_pkg::RWG_READY;
            else
              accum_q <= accum_q + 16'h0001;
          end
        end
        rwg_pkg::RWG_READY:
        begin
          if (rand_fire)
          begin
            state_q <= rwg_pkg::RWG_ACCUM;
            accum_q <= 16'h0000;
          end
        end
        // The unused code falls back to off rather than locking up
        default:
        begin
          state_q <= rwg_pkg::RWG_OFF;
          accum_q <= 16'h0000;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Register reads
  always_comb
  begin
    status_word = '0;
    status_word[rwg_pkg::OUTPUT_READY_BIT] = (state_q == rwg_pkg::RWG_READY);
    status_word[rwg_pkg::GEN_ON_BIT] = running;
  end

  always_comb
  begin
    if (pend_addr_q == rwg_pkg::STATE_FLAGS_OFS)
      answer = status_word;
    else if (pend_addr_q == rwg_pkg::RANDOM_WORD_OFS)
      answer = combined;
    else
      answer = rwg_pkg::UNMAPPED_WORD;
  end

  // Random reads wait for ready; other addresses answer at once
  assign fill_if.valid = pend_q && ((pend_addr_q != rwg_pkg::RANDOM_WORD_OFS) || rand_fire);
  assign fill_if.data = answer;
  assign push_fire = fill_if.valid && fill_if.ready;

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      pend_q <= 1'b0;
      pend_addr_q <= '0;
    end
    else if (!pend_q && rd_en_i)
    begin
      pend_q <= 1'b1;
      pend_addr_q <= rd_addr_i;
    end
    else if (push_fire)
      pend_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////
  // Answer register, stalled by the reader
  assign drain_if.ready = !out_valid_q || rd_ready_i;

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      out_valid_q <= 1'b0;
      out_data_q <= '0;
    end
    else if (drain_if.ready)
    begin
      out_valid_q <= drain_if.valid;
      if (drain_if.valid)
        out_data_q <= drain_if.data;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
      output_ready_o <= 1'b0;
    else
      output_ready_o <= (state_q == rwg_pkg::RWG_ACCUM) && step_lfsr && (accum_q == ACCUM_LAST)
        && gen_enable_i || (state_q == rwg_pkg::RWG_READY) && !rand_fire && gen_enable_i;
  end

  assign rd_busy_o = pend_q;
  assign rd_valid_o = out_valid_q;
  assign rd_data_o = out_data_q;
endmodule : rwg_generator

// *** bench/rwg_assertions.sv ***
module rwg_assertions #(
  parameter int unsigned ACCUM_STEPS = 2
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic gen_enable_i,
  input wire logic osc_lfsr_i,
  input wire logic osc_asr_i,
  input wire logic rd_en_i,
  input wire logic [11:0] rd_addr_i,
  input wire logic rd_ready_i,
  input wire logic rd_busy_o,
  input wire logic rd_valid_o,
  input wire logic [31:0] rd_data_o,
  input wire logic output_ready_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  logic rnd_q;
  logic [1:0] calm_q;
  wire take_rnd = rd_en_i && !rd_busy_o && rd_addr_i == rwg_pkg::RANDOM_WORD_OFS;
  // Flag lives from a random take until its answer is queued
  always_ff @(posedge clock_i)
    if (sys_rst_i || (!rd_busy_o && !take_rnd))
      rnd_q <= 1'b0;
    else if (take_rnd)
      rnd_q <= 1'b1;
  // Ready must hold only once the lagging flag has settled after a read
  always_ff @(posedge clock_i)
    if (sys_rst_i || !gen_enable_i || rnd_q || take_rnd)
      calm_q <= 2'h0;
    else if (calm_q != 2'h3)
      calm_q <= calm_q + 2'h1;
  AST_HOLD: assert property (rd_valid_o && !rd_ready_i |=> rd_valid_o && $stable(rd_data_o))
    else $error("answer moved while stalled");
  AST_TAKE_BUSY: assert property (rd_en_i && !rd_busy_o |=> rd_busy_o)
    else $error("take without busy");
  AST_IDLE_BUSY: assert property (!rd_en_i && !rd_busy_o |=> !rd_busy_o)
    else $error("busy without take");
  // The answer surfaces two edges after the push that ended the pending read
  AST_ANSWER: assert property ($rose(rd_valid_o) |-> $past(rd_busy_o, 2))
    else $error("answer without request");
  AST_QUIET: assert property (!rd_busy_o && !$past(rd_busy_o) && !rd_valid_o && !rd_en_i |=> !rd_valid_o)
    else $error("spurious answer");
  AST_READY_DROP: assert property (rnd_q && !rd_busy_o |-> ##[0:2] !output_ready_o)
    else $error("ready kept after read");
  AST_OFF: assert property (!gen_enable_i [*2] |=> !output_ready_o)
    else $error("ready while off");
  AST_READY_STAYS: assert property (output_ready_o && gen_enable_i && calm_q == 2'h3 && !take_rnd |=> output_ready_o)
    else $error("ready lost without read");
endmodule // rwg_assertions

bind rwg_generator rwg_assertions #(.ACCUM_STEPS(ACCUM_STEPS)) rwg_assertions_i (.clock_i(clock_i),
  .sys_rst_i(sys_rst_i), .gen_enable_i(gen_enable_i), .osc_lfsr_i(osc_lfsr_i), .osc_asr_i(osc_asr_i),
  .rd_en_i(rd_en_i), .rd_addr_i(rd_addr_i), .rd_ready_i(rd_ready_i), .rd_busy_o(rd_busy_o),
  .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .output_ready_o(output_ready_o));

// *** bench/rwg_bus_unit.sv ***
module rwg_bus_unit (
  input wire logic clock_i,
  input wire logic rd_busy_i,
  input wire logic rd_valid_i,
  input wire logic [31:0] rd_data_i,
  input wire logic output_ready_i,
  output logic rd_en_o,
  output logic [11:0] rd_addr_o,
  output logic rd_ready_o,
  output logic done_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic hold = 1'b0;
  logic [31:0] fifo [$];
  initial {rd_en_o, rd_addr_o, rd_ready_o, done_o} = '0;
  always @(posedge clock_i) rd_ready_o <= !hold;
  task automatic tick(inout int n);
    n++;
    if (n > 3000) rwg_generator_test.timeout_hit();
    @(posedge clock_i);
  endtask
  // Address is scrambled after the pulse so a stale value is never trusted
  task automatic issue(input logic [11:0] a);
    int n = 0;
    while (rd_busy_i !== 1'b0) tick(n);
    rd_en_o <= 1'b1;
    rd_addr_o <= a;
    @(posedge clock_i);
    rd_en_o <= 1'b0;
    rd_addr_o <= ~a;
    @(posedge clock_i);
  endtask
  task automatic get(output logic [31:0] d);
    int n = 0;
    while (!(rd_valid_i === 1'b1 && rd_ready_o)) tick(n);
    d = rd_data_i;
    @(posedge clock_i);
  endtask
  task automatic fetch(input int cnt);
    logic [31:0] d;
    int n;
    while (cnt > 0)
    begin
      n = 0;
      while (output_ready_i !== 1'b1) tick(n);
      issue(rwg_pkg::RANDOM_WORD_OFS);
      get(d);
      fifo.push_back(d);
      cnt--;
    end
    done_o <= 1'b1;
  endtask
endmodule // rwg_bus_unit

// *** bench/rwg_generator_test.sv ***
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin errors++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module rwg_generator_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic gen_enable_i = 1'b1;
  logic osc_lfsr_i = 1'b0;
  logic osc_asr_i = 1'b0;
  logic osc_run = 1'b0;
  logic rd_en_i, rd_ready_i, rd_busy_o, rd_valid_o, output_ready_o, done;
  logic [11:0] rd_addr_i;
  logic [31:0] rd_data_o, w, w0, e;
  logic [31:0] exp_q [$];
  logic [11:0] adr [4] = '{12'h604, 12'h600, 12'h7ff, 12'h600};
  int errors = 0;
  int tests_run = 0;
  always #25 clock_i = ~clock_i;
  // Random pin levels stand in for the free-running oscillators
  always @(posedge clock_i) if (osc_run) {osc_lfsr_i, osc_asr_i} <= 2'($urandom);
  rwg_generator #(.ACCUM_STEPS(2)) rwg_generator_i (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .gen_enable_i(gen_enable_i), .osc_lfsr_i(osc_lfsr_i), .osc_asr_i(osc_asr_i), .rd_en_i(rd_en_i),
    .rd_addr_i(rd_addr_i), .rd_ready_i(rd_ready_i), .rd_busy_o(rd_busy_o), .rd_valid_o(rd_valid_o),
    .rd_data_o(rd_data_o), .output_ready_o(output_ready_o));
  rwg_bus_unit rwg_bus_unit_i (.clock_i(clock_i), .rd_busy_i(rd_busy_o), .rd_valid_i(rd_valid_o),
    .rd_data_i(rd_data_o), .output_ready_i(output_ready_o), .rd_en_o(rd_en_i), .rd_addr_o(rd_addr_i),
    .rd_ready_o(rd_ready_i), .done_o(done));
  task automatic clk(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    rwg_bus_unit_i.issue(a);
    rwg_bus_unit_i.get(w);
    `CHK(w, x)
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic timeout_hit;
    errors++;
    tally_and_finish();
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(27502));
    clk(2);
    sys_rst_i <= 1'b0;
    clk(4);
    rd(12'h600, 32'h8000_0000);
    rd(12'h604, 32'h0000_0000);
    gen_enable_i <= 1'b0;
    clk(3);
    rd(12'h600, 32'h0000_0000);
    gen_enable_i <= 1'b1;
    osc_run <= 1'b1;
    clk(60);
    osc_run <= 1'b0;
    clk(3);
    `CHK(output_ready_o, 1'b1)
    rd(12'h600, 32'h8004_0000);
    rwg_bus_unit_i.issue(12'h602);
    rwg_bus_unit_i.get(w0);
    clk(2);
    rd(12'h600, 32'h8000_0000);
    // Stalled reader: three answers queue, the fourth request must wait
    rwg_bus_unit_i.hold <= 1'b1;
    foreach (adr[k])
    begin
      rwg_bus_unit_i.issue(adr[k]);
      exp_q.push_back(adr[k] == 12'h600 ? 32'h8000_0000 : 32'h0000_0000);
    end
    clk(5);
    `CHK(rd_busy_o, 1'b1)
    rwg_bus_unit_i.hold <= 1'b0;
    repeat (4)
    begin
      rwg_bus_unit_i.get(w);
      e = exp_q.pop_front();
      `CHK(w, e)
    end
    rwg_bus_unit_i.issue(12'h602);
    clk(20);
    `CHK(rd_busy_o, 1'b1)
    osc_run <= 1'b1;
    rwg_bus_unit_i.get(w);
    `CHK(w != w0, 1'b1)
    rwg_bus_unit_i.fetch(3);
    // The done flag is set by a non-blocking assignment; let it settle
    clk(1);
    `CHK(rwg_bus_unit_i.fifo.size(), 3)
    `CHK(done, 1'b1)
    `CHK(rwg_bus_unit_i.fifo[0] != rwg_bus_unit_i.fifo[2], 1'b1)
    tally_and_finish();
  end
endmodule // rwg_generator_test
